/* verilog/sapb_aux_bank.sv */
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module sapb_aux_bank
   import sapb_pkg::*;
#(
   parameter int CYCLES_PER_MS = CYC_PER_MS
)(
   input  wire logic           hclk,
   input  wire logic           hresetn,
   input  wire logic           hsel,
   input  wire logic [31:0]    haddr,
   input  wire logic [1:0]     htrans,
   input  wire logic           hwrite,
   input  wire logic [2:0]     hsize,
   input  wire logic [31:0]    hwdata,
   input  wire logic           hready,
   output logic                hreadyout,
   output logic                hresp,
   output logic [31:0]         hrdata,
   input  wire sapb_feedback_t fb,
   input  wire logic           brake_request,
   input  wire logic           power_up_event,
   input  wire logic [4:0]     rx_station_addr,
   input  wire logic           rx_addr_valid,
   output logic signed [15:0]  analog_monitor_one_out,
   output logic signed [15:0]  analog_monitor_two_out,
   output logic                brake_interlock_output,
   output logic                base_drive_shutoff,
   output logic                zero_speed_output,
   output logic                alarm_history_erase,
   output logic                station_match,
   output logic [15:0]         baud_divisor,
   output logic [15:0]         encoder_pulse_output_select
);
   // bus and register state
   logic [7:0]  wr_addr;
   logic        wr_pend;
   logic [15:0] mon_sel [2];
   logic [15:0] brake_delay;
   logic [15:0] zsd_thr;
   logic [15:0] ahc;
   logic [4:0]  station;
   logic [15:0] sio;
   logic [7:0]  next_wr_addr;
   logic        next_wr_pend;
   logic [15:0] next_mon_sel [2];
   logic [15:0] next_brake_delay;
   logic [15:0] next_zsd_thr;
   logic [15:0] next_ahc;
   logic [15:0] next_enc;
   logic [4:0]  next_station;
   logic [15:0] next_sio;
   logic [31:0] next_hrdata;
   logic        next_erase;
   logic        addr_ok;
   logic [15:0] wdata;
   logic [31:0] status;
   // function state
   sapb_brake_state_t  brk_state;
   sapb_brake_state_t  next_brk_state;
   logic [31:0]        cyc_cnt;
   logic [31:0]        next_cyc_cnt;
   logic [15:0]        ms_cnt;
   logic [15:0]        next_ms_cnt;
   logic               next_intlk;
   logic               next_shutoff;
   logic [15:0]        speed_abs;
   logic               next_zsd;
   logic               next_match;
   logic [15:0]        next_baud_div;
   logic               baud_bad;
   logic               next_baud_bad;
   sapb_mon_out_t      mon_res [2];
   logic signed [15:0] next_mon_val [2];
   logic [1:0]         mon_bad;
   logic [1:0]         next_mon_bad;

   assign addr_ok = hsel && hready && htrans[1];
   assign wdata   = hwdata[15:0];
   assign status  = {26'h0, baud_bad, mon_bad, base_drive_shutoff,
                     brake_interlock_output, zero_speed_output};

   // register file and AHB-Lite slave
   always_comb begin
      next_wr_pend     = addr_ok && hwrite;
      next_wr_addr     = addr_ok ? haddr[7:0] : wr_addr;
      next_mon_sel     = mon_sel;
      next_brake_delay = brake_delay;
      next_zsd_thr     = zsd_thr;
      next_ahc         = ahc;
      next_enc         = encoder_pulse_output_select;
      next_station     = station;
      next_sio         = sio;
      next_erase       = power_up_event && ahc[0];
      if (next_erase) begin
         next_ahc = 16'h0000;
      end
      if (wr_pend) begin
         case (wr_addr)
            ADDR_MON_ONE: next_mon_sel[0] = wdata;
            ADDR_MON_TWO: next_mon_sel[1] = wdata;
            ADDR_BRAKE:   next_brake_delay = (wdata > BRAKE_MAX_MS) ? BRAKE_MAX_MS : wdata;
            ADDR_ZSD:     next_zsd_thr = (wdata > ZSD_MAX) ? ZSD_MAX : wdata;
            ADDR_AHC:     next_ahc = wdata;
            ADDR_ENC:     next_enc = wdata;
            ADDR_STATION: next_station = wdata[4:0];
            ADDR_SIO:     next_sio = wdata;
            default:      next_sio = sio;
         endcase
      end
      next_hrdata = 32'h0000_0000;
      if (addr_ok && !hwrite) begin
         case (haddr[7:0])
            ADDR_MON_ONE: next_hrdata = {16'h0000, mon_sel[0]};
            ADDR_MON_TWO: next_hrdata = {16'h0000, mon_sel[1]};
            ADDR_BRAKE:   next_hrdata = {16'h0000, brake_delay};
            ADDR_ZSD:     next_hrdata = {16'h0000, zsd_thr};
            ADDR_AHC:     next_hrdata = {16'h0000, ahc};
            ADDR_ENC:     next_hrdata = {16'h0000, encoder_pulse_output_select};
            ADDR_STATION: next_hrdata = {27'h0000000, station};
            ADDR_SIO:     next_hrdata = {16'h0000, sio};
            ADDR_STATUS:  next_hrdata = status;
            default:      next_hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend     <= 1'b0;
         wr_addr     <= 8'h00;
         mon_sel[0]  <= RST_MON_ONE;
         mon_sel[1]  <= RST_MON_TWO;
         brake_delay <= RST_BRAKE;
         zsd_thr     <= RST_ZSD;
         ahc         <= RST_AHC;
         station     <= RST_STATION;
         sio         <= RST_SIO;
         hrdata      <= 32'h0000_0000;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         alarm_history_erase         <= 1'b0;
         encoder_pulse_output_select <= RST_ENC;
      end else begin
         wr_pend     <= next_wr_pend;
         wr_addr     <= next_wr_addr;
         mon_sel     <= next_mon_sel;
         brake_delay <= next_brake_delay;
         zsd_thr     <= next_zsd_thr;
         ahc         <= next_ahc;
         station     <= next_station;
         sio         <= next_sio;
         hrdata      <= next_hrdata;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         alarm_history_erase         <= next_erase;
         encoder_pulse_output_select <= next_enc;
      end
   end

   for (genvar ch = 0; ch < 2; ch++) begin : g_mon
      sapb_monitor_scale u_scale (
         .sel (mon_sel[ch]),
         .fb  (fb),
         .mon (mon_res[ch])
      );
      assign next_mon_val[ch] = mon_res[ch].value;
      assign next_mon_bad[ch] = mon_res[ch].invalid;
   end

   // brake sequence, zero speed, serial settings
   always_comb begin
      next_brk_state = brk_state;
      next_cyc_cnt   = cyc_cnt;
      next_ms_cnt    = ms_cnt;
      next_intlk     = brake_interlock_output;
      next_shutoff   = base_drive_shutoff;
      case (brk_state)
         BRK_RUN: begin
            next_cyc_cnt = 32'h0;
            next_ms_cnt  = 16'h0;
            if (brake_request) begin
               next_intlk     = 1'b1;
               next_shutoff   = (brake_delay == 16'h0);
               next_brk_state = (brake_delay == 16'h0) ? BRK_OFF : BRK_WAIT;
            end
         end
         BRK_WAIT: begin
            if (!brake_request) begin
               next_intlk     = 1'b0;
               next_brk_state = BRK_RUN;
            end else if (cyc_cnt == 32'(CYCLES_PER_MS - 1)) begin
               next_cyc_cnt = 32'h0;
               next_ms_cnt  = ms_cnt + 16'h1;
               if (ms_cnt == brake_delay - 16'h1) begin
                  next_shutoff   = 1'b1;
                  next_brk_state = BRK_OFF;
               end
            end else begin
               next_cyc_cnt = cyc_cnt + 32'h1;
            end
         end
         BRK_OFF: begin
            if (!brake_request) begin
               next_intlk     = 1'b0;
               next_shutoff   = 1'b0;
               next_brk_state = BRK_RUN;
            end
         end
         default: begin
            next_intlk     = 1'b0;
            next_shutoff   = 1'b0;
            next_brk_state = BRK_RUN;
         end
      endcase
      speed_abs = fb.motor_speed[15] ? 16'(-fb.motor_speed) : 16'(fb.motor_speed);
      if (zero_speed_output) begin
         next_zsd = ({1'b0, speed_abs} <= ({1'b0, zsd_thr} + ZSD_HYST));
      end else begin
         next_zsd = (speed_abs <= zsd_thr);
      end
      next_match = rx_addr_valid && (rx_station_addr == station);
      next_baud_bad = 1'b0;
      case (sio[3:0])
         4'h0:    next_baud_div = BAUD_DIV_0;
         4'h1:    next_baud_div = BAUD_DIV_1;
         4'h2:    next_baud_div = BAUD_DIV_2;
         4'h3:    next_baud_div = BAUD_DIV_3;
         4'h4:    next_baud_div = BAUD_DIV_4;
         // reserved baud falls back to slowest
         default: begin
            next_baud_div = BAUD_DIV_0;
            next_baud_bad = 1'b1;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         brk_state              <= BRK_RUN;
         cyc_cnt                <= 32'h0;
         ms_cnt                 <= 16'h0;
         brake_interlock_output <= 1'b0;
         base_drive_shutoff     <= 1'b0;
         zero_speed_output      <= 1'b0;
         station_match          <= 1'b0;
         baud_divisor           <= BAUD_DIV_0;
         baud_bad               <= 1'b0;
         analog_monitor_one_out <= 16'sh0000;
         analog_monitor_two_out <= 16'sh0000;
         mon_bad                <= 2'b00;
      end else begin
         brk_state              <= next_brk_state;
         cyc_cnt                <= next_cyc_cnt;
         ms_cnt                 <= next_ms_cnt;
         brake_interlock_output <= next_intlk;
         base_drive_shutoff     <= next_shutoff;
         zero_speed_output      <= next_zsd;
         station_match          <= next_match;
         baud_divisor           <= next_baud_div;
         baud_bad               <= next_baud_bad;
         analog_monitor_one_out <= next_mon_val[0];
         analog_monitor_two_out <= next_mon_val[1];
         mon_bad                <= next_mon_bad;
      end
   end

   // helper: cycles the interlock has led the shutoff
   logic [31:0] intlk_cycles;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         intlk_cycles <= 32'h0;
      end else if (!brake_interlock_output) begin
         intlk_cycles <= 32'h0;
      end else if (!base_drive_shutoff) begin
         intlk_cycles <= intlk_cycles + 32'h1;
      end
   end

   property p_intlk_first;
      @(posedge hclk) disable iff (!hresetn)
      (brk_state == BRK_RUN && brake_request) |=> brake_interlock_output;
   endproperty
   a_intlk_first: assert property (p_intlk_first) else $error("interlock late");

   property p_brake_delay;
      @(posedge hclk) disable iff (!hresetn)
      $rose(base_drive_shutoff) |-> intlk_cycles == 32'(brake_delay) * 32'(CYCLES_PER_MS);
   endproperty
   a_brake_delay: assert property (p_brake_delay) else $error("brake delay wrong");

   property p_zsd_on;
      @(posedge hclk) disable iff (!hresetn)
      (!zero_speed_output && speed_abs <= zsd_thr) |=> zero_speed_output;
   endproperty
   a_zsd_on: assert property (p_zsd_on) else $error("zero speed missed");

   property p_zsd_hyst;
      @(posedge hclk) disable iff (!hresetn)
      (zero_speed_output && speed_abs > zsd_thr &&
       {1'b0, speed_abs} <= {1'b0, zsd_thr} + ZSD_HYST) |=> zero_speed_output;
   endproperty
   a_zsd_hyst: assert property (p_zsd_hyst) else $error("hysteresis lost");

   property p_erase;
      @(posedge hclk) disable iff (!hresetn)
      (power_up_event && ahc[0]) |=> alarm_history_erase ##1 !alarm_history_erase;
   endproperty
   a_erase: assert property (p_erase) else $error("erase pulse wrong");

   property p_ahc_clear;
      @(posedge hclk) disable iff (!hresetn)
      (power_up_event && ahc[0] && !(wr_pend && wr_addr == ADDR_AHC)) |=> ahc == 16'h0000;
   endproperty
   a_ahc_clear: assert property (p_ahc_clear) else $error("clear field kept");

   property p_station;
      @(posedge hclk) disable iff (!hresetn)
      rx_addr_valid |=> station_match == ($past(rx_station_addr) == $past(station));
   endproperty
   a_station: assert property (p_station) else $error("station match wrong");

   property p_baud_fast;
      @(posedge hclk) disable iff (!hresetn)
      (sio[3:0] == 4'h4)[*2] |-> baud_divisor == BAUD_DIV_4;
   endproperty
   a_baud_fast: assert property (p_baud_fast) else $error("baud divisor wrong");

   property p_mon_reserved;
      @(posedge hclk) disable iff (!hresetn)
      (mon_sel[0] > SEL_BUS_VOLT) |=> analog_monitor_one_out == 16'sh0000 && mon_bad[0];
   endproperty
   a_mon_reserved: assert property (p_mon_reserved) else $error("reserved code used");

   c_shutoff: cover property (@(posedge hclk) disable iff (!hresetn) $rose(base_drive_shutoff));
   c_zsd_off: cover property (@(posedge hclk) disable iff (!hresetn) $fell(zero_speed_output));
   c_erase:   cover property (@(posedge hclk) disable iff (!hresetn) alarm_history_erase);
   c_match:   cover property (@(posedge hclk) disable iff (!hresetn) station_match);
endmodule

/* include/sapb_pkg.sv */
package sapb_pkg;

   // register byte offsets
   localparam logic [7:0] ADDR_MON_ONE = 8'h00;
   localparam logic [7:0] ADDR_MON_TWO = 8'h04;
   localparam logic [7:0] ADDR_BRAKE   = 8'h08;
   localparam logic [7:0] ADDR_ZSD     = 8'h0C;
   localparam logic [7:0] ADDR_AHC     = 8'h10;
   localparam logic [7:0] ADDR_ENC     = 8'h14;
   localparam logic [7:0] ADDR_STATION = 8'h18;
   localparam logic [7:0] ADDR_SIO     = 8'h1C;
   localparam logic [7:0] ADDR_STATUS  = 8'h20;

   // reset values
   localparam logic [15:0] RST_MON_ONE = 16'h0000;
   localparam logic [15:0] RST_MON_TWO = 16'h0001;
   localparam logic [15:0] RST_BRAKE   = 16'h0064;
   localparam logic [15:0] RST_ZSD     = 16'h0032;
   localparam logic [15:0] RST_AHC     = 16'h0000;
   localparam logic [15:0] RST_ENC     = 16'h0000;
   localparam logic [4:0]  RST_STATION = 5'h00;
   localparam logic [15:0] RST_SIO     = 16'h0000;

   // setting limits
   localparam logic [15:0] BRAKE_MAX_MS = 16'h03E8;
   localparam logic [15:0] ZSD_MAX      = 16'h2710;
   localparam logic [16:0] ZSD_HYST     = 17'h00014;

   // status bit positions
   localparam int ST_ZSD      = 0;
   localparam int ST_INTLK    = 1;
   localparam int ST_SHUTOFF  = 2;
   localparam int ST_MON1_BAD = 3;
   localparam int ST_MON2_BAD = 4;
   localparam int ST_BAUD_BAD = 5;

   // monitor selection codes
   localparam logic [15:0] SEL_SPEED_S   = 16'h0000;
   localparam logic [15:0] SEL_TORQUE_S  = 16'h0001;
   localparam logic [15:0] SEL_SPEED_U   = 16'h0002;
   localparam logic [15:0] SEL_TORQUE_U  = 16'h0003;
   localparam logic [15:0] SEL_CURRENT   = 16'h0004;
   localparam logic [15:0] SEL_PULSE_FRQ = 16'h0005;
   localparam logic [15:0] SEL_DROOP_100 = 16'h0006;
   localparam logic [15:0] SEL_DROOP_1K  = 16'h0007;
   localparam logic [15:0] SEL_DROOP_10K = 16'h0008;
   localparam logic [15:0] SEL_DROOP_10B = 16'h0009;
   localparam logic [15:0] SEL_FBPOS_1M  = 16'h000A;
   localparam logic [15:0] SEL_FBPOS_10M = 16'h000B;
   localparam logic [15:0] SEL_FBPOS_100M = 16'h000C;
   localparam logic [15:0] SEL_BUS_VOLT  = 16'h000D;

   // full-scale references
   localparam logic [31:0] FS_PULSE_FRQ = 32'h000F4240;
   localparam logic [31:0] FS_DROOP_100 = 32'h00000064;
   localparam logic [31:0] FS_DROOP_1K  = 32'h000003E8;
   localparam logic [31:0] FS_DROOP_10K = 32'h00002710;
   localparam logic [31:0] FS_FBPOS_1M  = 32'h000F4240;
   localparam logic [31:0] FS_FBPOS_10M = 32'h00989680;
   localparam logic [31:0] FS_FBPOS_100M = 32'h05F5E100;
   localparam logic [31:0] FS_BUS_LOW   = 32'h00000190;
   localparam logic [31:0] FS_BUS_HIGH  = 32'h00000320;
   localparam logic [15:0] MON_FULL_CODE = 16'h7FFF;

   // timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int MS_NS         = 1000000;
   localparam int CYC_PER_MS    = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
   localparam logic [15:0] BAUD_DIV_0 = 16'(CLK_HZ / 9600 - 1);
   localparam logic [15:0] BAUD_DIV_1 = 16'(CLK_HZ / 19200 - 1);
   localparam logic [15:0] BAUD_DIV_2 = 16'(CLK_HZ / 38400 - 1);
   localparam logic [15:0] BAUD_DIV_3 = 16'(CLK_HZ / 57600 - 1);
   localparam logic [15:0] BAUD_DIV_4 = 16'(CLK_HZ / 115200 - 1);

   typedef struct packed {
      logic signed [15:0] motor_speed;
      logic [15:0]        max_speed;
      logic signed [15:0] torque;
      logic [15:0]        max_torque;
      logic               torque_limit_active;
      logic [15:0]        forward_torque_limit;
      logic [15:0]        reverse_torque_limit;
      logic signed [15:0] current_cmd;
      logic [15:0]        max_current;
      logic signed [31:0] pulse_freq;
      logic signed [31:0] droop;
      logic signed [31:0] feedback_pos;
      logic [15:0]        bus_voltage;
      logic               high_voltage_class;
   } sapb_feedback_t;

   typedef struct packed {
      logic signed [15:0] value;
      logic               invalid;
   } sapb_mon_out_t;

   typedef enum logic [2:0] {
      BRK_RUN  = 3'b001,
      BRK_WAIT = 3'b010,
      BRK_OFF  = 3'b100
   } sapb_brake_state_t;

endpackage

/* verilog/sapb_monitor_scale.sv */
`timescale 1ns/1ps
module sapb_monitor_scale
   import sapb_pkg::*;
(
   input  wire logic [15:0]    sel,
   input  wire sapb_feedback_t fb,
   output sapb_mon_out_t       mon
);
   logic signed [31:0] quantity;
   logic [31:0]        full_scale;
   logic               unsigned_mode;
   logic               invalid;
   logic [15:0]        limit;
   logic [15:0]        torque_fs;
   logic [31:0]        mag;
   logic [47:0]        prod;
   logic [47:0]        quot;
   logic [15:0]        code;

   always_comb begin
      limit = (fb.forward_torque_limit > fb.reverse_torque_limit) ?
              fb.forward_torque_limit : fb.reverse_torque_limit;
      torque_fs = fb.max_torque;
      if (fb.torque_limit_active && limit != 16'h0000 && limit < fb.max_torque) begin
         torque_fs = limit;
      end
      quantity      = 32'sh0;
      full_scale    = 32'h1;
      unsigned_mode = 1'b0;
      invalid       = 1'b0;
      case (sel)
         SEL_SPEED_S, SEL_SPEED_U: begin
            quantity      = 32'(fb.motor_speed);
            full_scale    = {16'h0000, fb.max_speed};
            unsigned_mode = (sel == SEL_SPEED_U);
         end
         SEL_TORQUE_S, SEL_TORQUE_U: begin
            quantity      = 32'(fb.torque);
            full_scale    = {16'h0000, torque_fs};
            unsigned_mode = (sel == SEL_TORQUE_U);
         end
         SEL_CURRENT: begin
            quantity   = 32'(fb.current_cmd);
            full_scale = {16'h0000, fb.max_current};
         end
         SEL_PULSE_FRQ: begin
            quantity   = fb.pulse_freq;
            full_scale = FS_PULSE_FRQ;
         end
         SEL_DROOP_100, SEL_DROOP_1K, SEL_DROOP_10K, SEL_DROOP_10B: begin
            quantity   = fb.droop;
            full_scale = (sel == SEL_DROOP_100) ? FS_DROOP_100 :
                         (sel == SEL_DROOP_1K)  ? FS_DROOP_1K  : FS_DROOP_10K;
         end
         SEL_FBPOS_1M, SEL_FBPOS_10M, SEL_FBPOS_100M: begin
            quantity   = fb.feedback_pos;
            full_scale = (sel == SEL_FBPOS_1M)  ? FS_FBPOS_1M :
                         (sel == SEL_FBPOS_10M) ? FS_FBPOS_10M : FS_FBPOS_100M;
         end
         SEL_BUS_VOLT: begin
            quantity   = 32'({16'h0000, fb.bus_voltage});
            full_scale = fb.high_voltage_class ? FS_BUS_HIGH : FS_BUS_LOW;
         end
         default: begin
            invalid = 1'b1;
         end
      endcase
      mag  = quantity[31] ? 32'(-quantity) : 32'(quantity);
      prod = {16'h0000, mag} * {32'h00000000, MON_FULL_CODE};
      // a zero reference would divide by zero; show zero instead
      quot = (full_scale == 32'h0) ? 48'h0 : prod / {16'h0000, full_scale};
      code = (quot > 48'h7FFF) ? MON_FULL_CODE : quot[15:0];
      mon.invalid = invalid;
      if (invalid) begin
         mon.value = 16'sh0000;
      end else if (quantity[31] && !unsigned_mode) begin
         mon.value = 16'(-$signed(code));
      end else begin
         mon.value = $signed(code);
      end
   end
endmodule

/* verif/sapb_host_model.sv */
`timescale 1ns/1ps
module sapb_host_model (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       send,
   input  wire logic [4:0] dest,
   output logic [4:0]      rx_station_addr,
   output logic            rx_addr_valid
);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_addr_valid <= 1'b0;
         rx_station_addr <= 5'h00;
      end else begin
         rx_addr_valid <= send;
         // address toggles between frames so a stale value never matches by luck
         rx_station_addr <= send ? dest : ~rx_station_addr;
      end
   end
endmodule

/* verif/sapb_aux_bank_tb.sv */
`timescale 1ns/1ps
`define CHK(n,e,a) begin comparisons++; if ((a) !== (e)) begin err_count++; \
   $display("MISMATCH %s exp %h got %h", n, e, a); end end
module sapb_aux_bank_tb;
   import sapb_pkg::*;
   logic               hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_ph = 0, send = 0;
   logic               brake_request = 0, power_up_event = 0, hreadyout, hresp, rx_addr_valid;
   logic               brake_interlock_output, base_drive_shutoff, zero_speed_output;
   logic               alarm_history_erase, station_match;
   logic [1:0]         htrans = 2'h0;
   logic [2:0]         hsize = 3'h2;
   logic [4:0]         dest = 5'h00, rx_station_addr;
   logic [31:0]        haddr = 32'h0, hwdata = 32'h0, hrdata, e, seed = 32'hA904;
   logic signed [15:0] analog_monitor_one_out, analog_monitor_two_out;
   logic [15:0]        baud_divisor, encoder_pulse_output_select;
   sapb_feedback_t     fb = '0;
   int                 err_count = 0, comparisons = 0, n;
   logic [31:0]        exp_q[$];
   localparam logic [15:0] RV [8] = '{RST_MON_ONE, RST_MON_TWO, RST_BRAKE, RST_ZSD, RST_AHC,
      RST_ENC, 16'(RST_STATION), RST_SIO};
   localparam logic [15:0] ZS [6] = '{16'h0000, 16'h0046, 16'h0047, 16'h003C, 16'h0032, 16'hFFB9};
   localparam logic [15:0] MS [15] = '{SEL_SPEED_S, SEL_SPEED_U, SEL_TORQUE_S, SEL_TORQUE_U,
      SEL_CURRENT, SEL_PULSE_FRQ, SEL_DROOP_100, SEL_DROOP_1K, SEL_DROOP_10K, SEL_DROOP_10B,
      SEL_FBPOS_1M, SEL_FBPOS_10M, SEL_FBPOS_100M, SEL_BUS_VOLT, 16'h000E};
   localparam logic [15:0] ME [15] = '{16'h8001, 16'h7FFF, 16'h7FFF, 16'h7FFF, 16'h3FFF,
      16'h3FFF, 16'h8001, 16'hF334, 16'hFEB9, 16'hFEB9, 16'h7FFF, 16'h0CCC, 16'h0147,
      16'h7FFF, 16'h0000};
   localparam logic [15:0] BD [6] = '{BAUD_DIV_0, BAUD_DIV_1, BAUD_DIV_2, BAUD_DIV_3,
      BAUD_DIV_4, BAUD_DIV_0};

   always #2.5 hclk = ~hclk;

   sapb_aux_bank #(.CYCLES_PER_MS(10)) uut (.*, .hready(hreadyout));
   sapb_host_model host (.hclk(hclk), .hresetn(hresetn), .send(send), .dest(dest),
      .rx_station_addr(rx_station_addr), .rx_addr_valid(rx_addr_valid));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic bus(input logic w, input logic [31:0] a, d, x);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rd_ph <= !w;
      if (!w) exp_q.push_back(x);
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_ph <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] a, d);
      bus(1'b1, a, d, 32'h0);
   endtask
   task automatic rd(input logic [31:0] a, x);
      bus(1'b0, a, 32'h0, x);
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge hclk);
      #1;
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // read results are compared in order as their data phase closes
   always @(posedge hclk) begin
      if (rd_ph && hreadyout === 1'b1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         `CHK("hrdata", e, hrdata)
         `CHK("hresp", 1'b0, hresp)
      end
   end

   initial begin
      #20000;
      err_count++;
      finish_test;
   end

   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 8; i++) rd(32'(4 * i), 32'(RV[i]));
      wr(32'h40, 32'hFFFF);
      rd(32'h40, 32'h0);
      $display("test reset values done");
      for (int i = 0; i < 6; i++) begin
         @(posedge hclk);
         fb.motor_speed <= ZS[i];
         cyc(2);
         `CHK("zero_speed_output", 6'h13 >> i & 1'b1, zero_speed_output)
      end
      $display("test zero speed done");
      @(posedge hclk);
      fb <= '{16'hFC18, 16'h03E8, 16'h0064, 16'h00C8, 1'b1, 16'h0064, 16'h0064, 16'h0032,
         16'h0064, 32'h0007A120, 32'hFFFFFF9C, 32'h000F4240, 16'h0320, 1'b1};
      for (int i = 0; i < 15; i++) begin
         wr(32'h0, 32'(MS[i]));
         cyc(2);
         `CHK("analog_monitor_one_out", ME[i], analog_monitor_one_out)
      end
      `CHK("analog_monitor_two_out", 16'h7FFF, analog_monitor_two_out)
      rd(32'h20, 32'h8);
      $display("test monitors done");
      for (int i = 0; i < 6; i++) begin
         wr(32'h1C, 32'(i));
         cyc(2);
         `CHK("baud_divisor", BD[i], baud_divisor)
      end
      rd(32'h20, 32'h28);
      $display("test baud done");
      wr(32'h8, 32'h2);
      @(posedge hclk);
      brake_request <= 1'b1;
      while (brake_interlock_output !== 1'b1) begin
         @(posedge hclk);
         #1;
      end
      n = 0;
      while (base_drive_shutoff !== 1'b1) begin
         @(posedge hclk);
         #1;
         n++;
      end
      `CHK("brake delay", 20, n)
      @(posedge hclk);
      brake_request <= 1'b0;
      cyc(1);
      `CHK("brake_interlock_output", 1'b0, brake_interlock_output)
      wr(32'h8, 32'h7D0);
      rd(32'h8, 32'h3E8);
      $display("test brake done");
      wr(32'h10, 32'h1);
      @(posedge hclk);
      power_up_event <= 1'b1;
      @(posedge hclk);
      power_up_event <= 1'b0;
      #1;
      `CHK("alarm_history_erase", 1'b1, alarm_history_erase)
      rd(32'h10, 32'h0);
      $display("test alarm clear done");
      wr(32'h18, 32'h25);
      rd(32'h18, 32'h5);
      for (int i = 0; i < 5; i++) begin
         seed = lfsr(seed);
         @(posedge hclk);
         send <= 1'b1;
         dest <= i == 0 ? 5'h05 : seed[4:0];
         @(posedge hclk);
         send <= 1'b0;
         cyc(1);
         `CHK("station_match", dest == 5'h05, station_match)
      end
      seed = lfsr(seed);
      wr(32'h14, seed);
      cyc(1);
      `CHK("encoder_pulse_output_select", seed[15:0], encoder_pulse_output_select)
      $display("test station done");
      finish_test;
   end
endmodule
